// ===== smmc_pkg.sv
package smmc_pkg;
    // Operating modes
    typedef enum logic [1:0] {
        SMMC_STOP  = 2'b00,
        SMMC_REASN = 2'b01,
        SMMC_RUN   = 2'b10
    } smmc_mode_t;

    // Protocol and line interface selection
    localparam logic [1:0] SMMC_PROT_3964   = 2'h0;
    localparam logic [1:0] SMMC_PROT_ASCII  = 2'h1;
    localparam logic [1:0] SMMC_IF_RS422_MP = 2'h0;
    localparam logic [1:0] SMMC_IF_RS485    = 2'h1;

    // Status word codes
    localparam logic [7:0] SMMC_EVC_ABORT   = 8'h1E;
    localparam logic [7:0] SMMC_EVN_ABORT   = 8'h0D;
    localparam logic [7:0] SMMC_EVC_START   = 8'h00;
    localparam logic [7:0] SMMC_EVN_INIT    = 8'h01;
    localparam logic [7:0] SMMC_EVN_APPLIED = 8'h03;
    localparam logic [7:0] SMMC_EVN_SAME    = 8'h04;
    localparam logic [7:0] SMMC_EVN_TOSTOP  = 8'h07;
    localparam logic [7:0] SMMC_EVN_TORUN   = 8'h08;
    localparam logic [7:0] SMMC_EVN_NAK     = 8'h02;

    // Handler calls the host must make to resynchronise after restart
    localparam logic [1:0] SMMC_SYNC_CALLS  = 2'h3;
    // Counter value that ends a reassignment, which lasts nine cycles
    localparam logic [3:0] SMMC_REASN_CYC   = 4'h8;
    localparam int         SMMC_PARAM_W     = 16;

    // Parameter set
    typedef struct packed {
        logic       valid;      // Set is legal
        logic [1:0] prot;       // Protocol driver
        logic [1:0] ifmode;     // Line interface mode
        logic       flow;       // Flow control on
        logic       rx_on_stop; // Keep receiving on host stop (ASCII without flow control only)
        logic [8:0] misc;       // Other settings
    } smmc_param_t;

    // Status word
    typedef struct packed {
        logic [7:0] evc;        // Event class
        logic [7:0] evn;        // Event number
    } smmc_status_t;
endpackage

// ===== smmc_ctrl.sv
////////////////////////////////////////////////////////////////////////////////
module smmc_ctrl #(
    parameter int DW = 8                              // Frame data width
) (
    input  wire logic                  i_sys_clk,     // System clock
    input  wire logic                  i_rst_n,       // Async reset, low
    input  wire logic                  i_pwr_ok,      // Module energised (pin)
    input  wire logic                  i_cc_on,       // Central controller on (pin)
    input  wire logic                  i_line_break,  // Line break seen (pin)
    input  wire logic                  i_host_run,    // Host in run (pin)
    input  wire logic                  i_param_load,  // Parameter set offered
    input  wire smmc_pkg::smmc_param_t i_param,       // Offered parameter set
    input  wire logic                  i_call,        // Handler invocation strobe
    input  wire logic                  i_send_req,    // Host send request
    input  wire logic                  i_recv_req,    // Host fetch request
    input  wire logic                  i_wr_valid,    // Host frame byte valid
    input  wire logic [DW-1:0]         i_wr_data,     // Host frame byte
    input  wire logic                  i_wr_last,     // Last byte of frame
    input  wire logic                  i_tx_busy,     // Serial sender busy
    input  wire logic                  i_tx_ready,    // Serial sender takes byte
    input  wire logic                  i_rx_frame,    // Frame waiting from partner
    output logic                       o_wr_ready,    // Host byte accepted
    output logic                       o_tx_valid,    // Byte for serial sender
    output logic [DW-1:0]              o_tx_data,     // Byte to send
    output logic                       o_drv_rst,     // Protocol driver reset
    output logic                       o_drv_en,      // Protocol driver active
    output logic                       o_rx_en,       // Serial reception allowed
    output logic                       o_rx_avail,    // Received frame held
    output logic                       o_ack,         // Request positive ack
    output logic                       o_nak,         // Request negative ack
    output logic                       o_line_out,    // Line driver level
    output logic                       o_line_oe,     // Line driver enable
    output logic [1:0]                 o_mode,        // Current mode
    output smmc_pkg::smmc_status_t     o_status       // Status word
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pwr_s_r, cc_s_r, brk_s_r, run_s_r;   // Three-stage chains
    logic       pwr_r, cc_r, brk_r, run_r;           // Filtered levels

    // Shift pins and accept when stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_s_r <= 3'h0;
            cc_s_r  <= 3'h0;
            brk_s_r <= 3'h0;
            run_s_r <= 3'h0;
            pwr_r   <= 1'b0;
            cc_r    <= 1'b0;
            brk_r   <= 1'b0;
            run_r   <= 1'b0;
        end else begin
            pwr_s_r <= {pwr_s_r[1:0], i_pwr_ok};
            cc_s_r  <= {cc_s_r[1:0], i_cc_on};
            brk_s_r <= {brk_s_r[1:0], i_line_break};
            run_s_r <= {run_s_r[1:0], i_host_run};
            if (pwr_s_r[2] == pwr_s_r[1]) pwr_r <= pwr_s_r[2];
            if (cc_s_r[2] == cc_s_r[1])   cc_r  <= cc_s_r[2];
            if (brk_s_r[2] == brk_s_r[1]) brk_r <= brk_s_r[2];
            if (run_s_r[2] == run_s_r[1]) run_r <= run_s_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode machine
    smmc_pkg::smmc_mode_t mode_r, mode_nxt;          // Mode
    smmc_pkg::smmc_param_t par_r;                    // Held parameters
    logic       have_par_r;                          // Parameters assigned
    logic [3:0] rcnt_r;                              // Reassignment counter
    logic       run_d_r;                             // Host run delayed
    logic       host_stop_ev, host_start_ev;         // Host edges
    logic       par_diff, do_reasn, stop_cause;

    assign host_stop_ev  = run_d_r & ~run_r;
    assign host_start_ev = ~run_d_r & run_r;
    assign par_diff      = !have_par_r || (i_param != par_r);
    assign do_reasn      = i_param_load && i_param.valid && par_diff;
    assign stop_cause    = brk_r || !have_par_r || !par_r.valid;

    // Next mode
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            smmc_pkg::SMMC_STOP: begin
                if (do_reasn) begin
                    mode_nxt = smmc_pkg::SMMC_REASN;
                end else if (!stop_cause) begin
                    mode_nxt = smmc_pkg::SMMC_RUN;
                end
            end
            smmc_pkg::SMMC_REASN: begin
                if (rcnt_r == smmc_pkg::SMMC_REASN_CYC) begin
                    mode_nxt = smmc_pkg::SMMC_RUN;
                end
            end
            smmc_pkg::SMMC_RUN: begin
                if (do_reasn) begin
                    mode_nxt = smmc_pkg::SMMC_REASN;
                end else if (stop_cause) begin
                    mode_nxt = smmc_pkg::SMMC_STOP;
                end
            end
            default: mode_nxt = smmc_pkg::SMMC_STOP;
        endcase
    end

    // Mode register, reassignment count, parameters
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r     <= smmc_pkg::SMMC_STOP;
            rcnt_r     <= 4'h0;
            par_r      <= '0;
            have_par_r <= 1'b0;
            run_d_r    <= 1'b0;
        end else begin
            mode_r  <= mode_nxt;
            run_d_r <= run_r;
            rcnt_r  <= (mode_r == smmc_pkg::SMMC_REASN) ? rcnt_r + 4'h1 : 4'h0;
            if (do_reasn) begin
                par_r      <= i_param;
                have_par_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host resynchronisation
    logic [1:0] sync_r;                               // Calls still needed
    logic       synced, flush;

    assign synced = (sync_r == 2'h0);
    assign flush  = (mode_r != smmc_pkg::SMMC_RUN) || host_stop_ev;

    // Count handler calls after host start before requests run
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_r <= smmc_pkg::SMMC_SYNC_CALLS;
        end else if (host_start_ev || mode_r == smmc_pkg::SMMC_REASN) begin
            sync_r <= smmc_pkg::SMMC_SYNC_CALLS;
        end else if (i_call && !synced) begin
            sync_r <= sync_r - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry frame buffer; sending held until whole frame in
    logic [DW-1:0] buf_r [2];                         // Data entries
    logic [1:0]    blast_r;                           // Last flags
    logic          wp_r, rp_r;                        // Pointers
    logic [1:0]    cnt_r;                             // Fill
    logic          frame_in_r;                        // Frame complete
    logic          pend_r;                            // Retained send request
    logic          push, pop, accept, tx_go;

    assign accept = run_r && mode_r == smmc_pkg::SMMC_RUN;
    assign push   = i_wr_valid && o_wr_ready;
    assign tx_go  = frame_in_r && pend_r && synced && !i_tx_busy;
    assign pop    = o_tx_valid && i_tx_ready;

    // Buffer storage and pointers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r    <= 1'b0;
            rp_r    <= 1'b0;
            cnt_r   <= 2'h0;
            blast_r <= 2'h0;
            buf_r   <= '{default: '0};
        end else if (flush) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                buf_r[wp_r]   <= i_wr_data;
                blast_r[wp_r] <= i_wr_last;
                wp_r          <= ~wp_r;
            end
            if (pop) rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Frame-complete and retained request flags
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_in_r <= 1'b0;
            pend_r     <= 1'b0;
        end else if (flush) begin
            frame_in_r <= 1'b0;
            pend_r     <= 1'b0;
        end else begin
            if (push && i_wr_last) frame_in_r <= 1'b1;
            else if (pop && blast_r[rp_r]) frame_in_r <= 1'b0;
            if (i_send_req && accept) pend_r <= 1'b1;
            else if (pop && blast_r[rp_r]) pend_r <= 1'b0;
        end
    end

    // Host-side ready and sender data
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_ready <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_data  <= '0;
        end else begin
            o_wr_ready <= accept && !flush && !frame_in_r &&
                          (cnt_r + {1'b0, push} < 2'h2);
            o_tx_valid <= !flush && tx_go && cnt_r != 2'h0 && !(pop && cnt_r == 2'h1);
            o_tx_data  <= buf_r[pop ? ~rp_r : rp_r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge, status and driver control
    logic abort_pend_r;                               // Host transfer was cut

    // Report cut host transfers after restart
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            abort_pend_r <= 1'b0;
        end else if (host_stop_ev && (cnt_r != 2'h0 || pend_r)) begin
            abort_pend_r <= 1'b1;
        end else if (synced && o_status.evc == smmc_pkg::SMMC_EVC_ABORT) begin
            abort_pend_r <= 1'b0;
        end
    end

    // Request answers and status word
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack    <= 1'b0;
            o_nak    <= 1'b0;
            o_status <= '{evc: smmc_pkg::SMMC_EVC_START, evn: smmc_pkg::SMMC_EVN_INIT};
        end else begin
            o_ack <= 1'b0;
            o_nak <= 1'b0;
            if (i_send_req || i_recv_req) begin
                if (mode_r != smmc_pkg::SMMC_RUN) begin
                    o_nak    <= 1'b1;
                    o_status <= '{evc: smmc_pkg::SMMC_EVC_START,
                                  evn: smmc_pkg::SMMC_EVN_NAK};
                end else if (abort_pend_r && synced) begin
                    o_nak    <= 1'b1;
                    o_status <= '{evc: smmc_pkg::SMMC_EVC_ABORT,
                                  evn: smmc_pkg::SMMC_EVN_ABORT};
                end else if (synced && (i_recv_req ? i_rx_frame : 1'b1)) begin
                    o_ack <= 1'b1;
                end
            end else if (host_stop_ev) begin
                o_status <= '{evc: smmc_pkg::SMMC_EVC_START, evn: smmc_pkg::SMMC_EVN_TOSTOP};
            end else if (host_start_ev) begin
                o_status <= '{evc: smmc_pkg::SMMC_EVC_START, evn: smmc_pkg::SMMC_EVN_TORUN};
            end else if (i_param_load) begin
                o_status <= '{evc: smmc_pkg::SMMC_EVC_START,
                              evn: par_diff ? smmc_pkg::SMMC_EVN_APPLIED
                                            : smmc_pkg::SMMC_EVN_SAME};
            end
        end
    end

    // Driver enables and idle line level
    logic ascii_nf;
    assign ascii_nf = par_r.prot == smmc_pkg::SMMC_PROT_ASCII && !par_r.flow;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drv_rst  <= 1'b1;
            o_drv_en   <= 1'b0;
            o_rx_en    <= 1'b0;
            o_rx_avail <= 1'b0;
            o_line_out <= 1'b0;
            o_line_oe  <= 1'b0;
            o_mode     <= 2'h0;
        end else begin
            o_mode     <= mode_r;
            o_drv_rst  <= mode_r == smmc_pkg::SMMC_REASN;
            o_drv_en   <= mode_r == smmc_pkg::SMMC_RUN;
            // Host stop: ASCII without flow control keeps receiving when rx_on_stop is set
            o_rx_en    <= mode_r == smmc_pkg::SMMC_RUN &&
                          (run_r || (ascii_nf && par_r.rx_on_stop));
            o_rx_avail <= mode_r == smmc_pkg::SMMC_RUN && i_rx_frame;
            o_line_out <= 1'b1;
            if (!pwr_r || !cc_r || !have_par_r) begin
                o_line_oe <= 1'b0;
            end else if (par_r.prot == smmc_pkg::SMMC_PROT_ASCII &&
                         par_r.ifmode == smmc_pkg::SMMC_IF_RS485) begin
                o_line_oe <= i_tx_busy;
            end else begin
                o_line_oe <= 1'b1;
            end
        end
    end
endmodule

// ===== smmc_ctrl_asserts.sv
module smmc_ctrl_asserts (
    input  wire logic                   i_sys_clk,    // System clock
    input  wire logic                   i_rst_n,      // Async reset, low
    input  wire logic                   i_line_break, // Line break pin
    input  wire logic                   i_send_req,   // Host send request
    input  wire logic                   i_recv_req,   // Host fetch request
    input  wire logic                   i_wr_valid,   // Host byte valid
    input  wire logic                   i_wr_last,    // Last host byte
    input  wire logic                   i_tx_busy,    // Serial sender busy
    input  wire logic                   o_wr_ready,   // Host byte accepted
    input  wire logic                   o_tx_valid,   // Byte for sender
    input  wire logic                   o_drv_rst,    // Driver reset
    input  wire logic                   o_drv_en,     // Driver active
    input  wire logic                   o_ack,        // Positive ack
    input  wire logic                   o_nak,        // Negative ack
    input  wire logic                   o_line_out,   // Line level
    input  wire logic                   o_line_oe,    // Line enable
    input  wire logic [1:0]             o_mode,       // Current mode
    input  wire smmc_pkg::smmc_status_t o_status      // Status word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic params_r; // A reassignment was seen
    logic frame_r;  // A whole host frame was taken
    ////////////////////////////////////////////////////////////////////////////
    // Remember that parameters were applied once
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) params_r <= 1'b0;
        else if (o_mode == 2'h1) params_r <= 1'b1;
    end
    // Remember a completed frame while running
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) frame_r <= 1'b0;
        else if (o_mode != 2'h2) frame_r <= 1'b0;
        else if (i_wr_valid && o_wr_ready && i_wr_last) frame_r <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Request, then the mode it met shows one sample later
    sequence s_idle_req;
        (i_send_req || i_recv_req) ##1 o_mode != 2'h2;
    endsequence
    // Mode held for two samples
    sequence s_held_stop;
        o_mode == 2'h0 && $past(o_mode) == 2'h0;
    endsequence
    sequence s_held_reasn;
        o_mode == 2'h1 && $past(o_mode) == 2'h1;
    endsequence
    a_stop_nak: assert property (s_idle_req |-> o_nak && !o_ack)
        else $error("request outside run not refused");
    a_stop_drv: assert property (s_held_stop |-> !o_drv_en)
        else $error("driver active in stop");
    a_reasn_flush: assert property (s_held_reasn |-> o_drv_rst && !o_wr_ready && !o_tx_valid)
        else $error("reassignment did not hold driver and buffer");
    a_reasn_end: assert property ($rose(o_mode == 2'h1) |-> ##[1:11] o_mode != 2'h1)
        else $error("reassignment did not finish");
    a_ack_run: assert property (o_ack |-> o_mode == 2'h2 && !o_nak)
        else $error("ack outside run");
    a_tx_whole: assert property ($rose(o_tx_valid) |-> frame_r)
        else $error("send began before frame complete");
    a_hiz_noparam: assert property (!params_r && o_mode != 2'h1 |-> !o_line_oe && o_mode != 2'h2)
        else $error("line driven or run without parameters");
    a_idle_high: assert property (o_line_oe && !i_tx_busy && $past(!i_tx_busy) |-> o_line_out)
        else $error("idle line not high");
    a_abort_code: assert property (o_status.evc == smmc_pkg::SMMC_EVC_ABORT |->
        o_status.evn == smmc_pkg::SMMC_EVN_ABORT)
        else $error("abort status number wrong");
    a_break_hold: assert property (o_mode == 2'h0 && i_line_break && $past(i_line_break, 5)
        |=> o_mode == 2'h0)
        else $error("stop left during line break");
endmodule
bind smmc_ctrl smmc_ctrl_asserts smmc_ctrl_asserts_i (.i_sys_clk, .i_rst_n, .i_line_break,
    .i_send_req, .i_recv_req, .i_wr_valid, .i_wr_last, .i_tx_busy, .o_wr_ready, .o_tx_valid,
    .o_drv_rst, .o_drv_en, .o_ack, .o_nak, .o_line_out, .o_line_oe, .o_mode, .o_status);

// ===== smmc_serial_model.sv
module smmc_serial_model (
    input  wire logic       i_clk,      // System clock
    input  wire logic       i_rst_n,    // Async reset, low
    input  wire logic       i_valid,    // Byte offered
    input  wire logic [7:0] i_data,     // Byte offered
    input  wire logic       i_stall,    // Hold off taking bytes
    input  wire logic       i_rx_hold,  // A frame has arrived
    output logic            o_ready,    // Byte taken at this edge
    output logic            o_busy,     // Shifting a byte out
    output logic            o_rx_frame, // Received frame waiting
    output logic [7:0]      o_byte,     // Last byte taken
    output logic            o_stb       // One pulse per byte taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] busy_r; // Shift cycles left
    assign o_busy     = busy_r != 2'h0;
    assign o_rx_frame = i_rx_hold;
    // Take a byte, then stay busy so the sender looks slow
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'b0;
            o_stb   <= 1'b0;
            o_byte  <= 8'h00;
            busy_r  <= 2'h0;
        end else begin
            o_stb   <= i_valid && o_ready;
            o_byte  <= (i_valid && o_ready) ? i_data : o_byte;
            busy_r  <= (i_valid && o_ready) ? 2'h3 : (o_busy ? busy_r - 2'h1 : 2'h0);
            o_ready <= !i_stall && !o_busy && !(i_valid && o_ready);
        end
    end
endmodule

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   sys_clk, rst_n, pwr_ok, cc_on, line_break, host_run; // Pins
    logic                   param_load, call, send_req, recv_req, wr_valid, wr_last; // Host
    logic                   tx_busy, tx_ready, rx_frame, stall, rx_hold, got_stb; // Far side
    logic                   wr_ready, tx_valid, drv_rst, drv_en, rx_en, rx_avail; // Outputs
    logic                   ack, nak, line_out, line_oe; // Outputs
    logic [7:0]             wr_data, tx_data, got_byte, exp_q[$]; // Data path
    logic [1:0]             mode;       // Current mode
    smmc_pkg::smmc_param_t  param, cur; // Offered and held sets
    smmc_pkg::smmc_status_t status;     // Status word
    int                     error_cnt, samples_checked, cyc; // Counters
    integer                 seed;       // Random seed
    smmc_ctrl #(.DW(8)) smmc_ctrl_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_pwr_ok(pwr_ok),
        .i_cc_on(cc_on), .i_line_break(line_break), .i_host_run(host_run),
        .i_param_load(param_load), .i_param(param), .i_call(call), .i_send_req(send_req),
        .i_recv_req(recv_req), .i_wr_valid(wr_valid), .i_wr_data(wr_data), .i_wr_last(wr_last),
        .i_tx_busy(tx_busy), .i_tx_ready(tx_ready), .i_rx_frame(rx_frame),
        .o_wr_ready(wr_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_drv_rst(drv_rst),
        .o_drv_en(drv_en), .o_rx_en(rx_en), .o_rx_avail(rx_avail), .o_ack(ack), .o_nak(nak),
        .o_line_out(line_out), .o_line_oe(line_oe), .o_mode(mode), .o_status(status));
    smmc_serial_model smmc_serial_model_i (.i_clk(sys_clk), .i_rst_n(rst_n), .i_valid(tx_valid),
        .i_data(tx_data), .i_stall(stall), .i_rx_hold(rx_hold), .o_ready(tx_ready),
        .o_busy(tx_busy), .o_rx_frame(rx_frame), .o_byte(got_byte), .o_stb(got_stb));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // Bytes reaching the serial side must match the frames written
    always @(negedge sys_clk) begin
        if (got_stb === 1'b1) chk(16'(got_byte), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hxxxx);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic load(input smmc_pkg::smmc_param_t p);
        @(posedge sys_clk);
        param      <= p;
        param_load <= 1'b1;
        @(posedge sys_clk);
        param_load <= 1'b0;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int i = 0; i < 40 && mode !== m; i++) @(negedge sys_clk);
        chk(16'(mode), 16'(m));
    endtask
    // One request pulse, answer looked at in the following cycle
    task automatic req(input bit rd, input logic a, input logic n);
        @(posedge sys_clk);
        if (rd) recv_req <= 1'b1;
        else send_req <= 1'b1;
        @(posedge sys_clk);
        recv_req <= 1'b0;
        send_req <= 1'b0;
        #1;
        chk(16'({ack, nak}), 16'({a, n}));
    endtask
    // Three handler invocations resynchronise the host side
    task automatic calls();
        repeat (3) begin
            @(posedge sys_clk);
            call <= 1'b1;
            @(posedge sys_clk);
            call <= 1'b0;
        end
    endtask
    // Write n host bytes; fin marks the last one
    task automatic frame(input int n, input bit fin);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            @(posedge sys_clk);
            wr_valid <= 1'b1;
            wr_data  <= b;
            wr_last  <= fin && (i == n - 1);
            @(negedge sys_clk);
            for (int k = 0; k < 50 && wr_ready !== 1'b1; k++) @(negedge sys_clk);
            chk(16'(wr_ready), 16'h0001);
            if (fin) exp_q.push_back(b);
            @(posedge sys_clk);
            wr_valid <= 1'b0;
        end
    endtask
    task automatic drain();
        for (int k = 0; k < 200 && exp_q.size() != 0; k++) @(negedge sys_clk);
        chk(16'(exp_q.size()), 16'h0000);
    endtask
    function automatic smmc_pkg::smmc_param_t mk(input logic v, input logic [1:0] pr, im);
        mk = '{valid: v, prot: pr, ifmode: im, flow: 1'b0, rx_on_stop: 1'b0, misc: 9'($random(seed))};
    endfunction
    // Idle drive expected unless ASCII on RS485
    function automatic logic exp_oe(input smmc_pkg::smmc_param_t p);
        return !(p.prot == smmc_pkg::SMMC_PROT_ASCII && p.ifmode == smmc_pkg::SMMC_IF_RS485);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hc27d_a935;
        {rst_n, param_load, call, send_req, recv_req, wr_valid, wr_last, line_break} = '0;
        {pwr_ok, cc_on, host_run, stall, rx_hold} = 5'b11100;
        param   = '0;
        wr_data = 8'h00;
        tick(8);
        rst_n <= 1'b1;
        tick(2);
        chk(status, {smmc_pkg::SMMC_EVC_START, smmc_pkg::SMMC_EVN_INIT});
        tick(4);
        chk(16'(mode), 16'h0000);
        chk(16'(line_oe), 16'h0000);
        req(0, 1'b0, 1'b1);
        chk(status, {smmc_pkg::SMMC_EVC_START, smmc_pkg::SMMC_EVN_NAK});
        load(mk(1'b0, smmc_pkg::SMMC_PROT_3964, smmc_pkg::SMMC_IF_RS422_MP));
        tick(12);
        chk(16'(mode), 16'h0000);
        cur = mk(1'b1, smmc_pkg::SMMC_PROT_3964, smmc_pkg::SMMC_IF_RS422_MP);
        load(cur);
        wait_mode(2'h1);
        chk(16'({wr_ready, drv_rst}), 16'h0001);
        wait_mode(2'h2);
        tick(2);
        chk(16'({line_oe, line_out}), 16'({exp_oe(cur), 1'b1}));
        load(cur);
        tick(3);
        chk(16'(mode), 16'h0002);
        chk(status, {smmc_pkg::SMMC_EVC_START, smmc_pkg::SMMC_EVN_SAME});
        req(0, 1'b0, 1'b0);
        calls();
        frame(2, 1'b1);
        drain();
        req(1, 1'b0, 1'b0);
        rx_hold <= 1'b1;
        tick(4);
        chk(16'({rx_avail, rx_en}), 16'h0003);
        req(1, 1'b1, 1'b0);
        rx_hold <= 1'b0;
        repeat (6) begin
            stall <= 1'($random(seed));
            frame(1 + ($random(seed) & 1), 1'b1);
            req(0, 1'b1, 1'b0);
            tick(5);
            stall <= 1'b0;
            drain();
        end
        cur = mk(1'b1, smmc_pkg::SMMC_PROT_ASCII, smmc_pkg::SMMC_IF_RS485);
        load(cur);
        wait_mode(2'h1);
        chk(16'(tx_valid), 16'h0000);
        wait_mode(2'h2);
        tick(2);
        chk(16'(line_oe), 16'(exp_oe(cur)));
        calls();
        frame(1, 1'b0);
        host_run <= 1'b0;
        tick(8);
        chk(16'({wr_ready, rx_en}), 16'h0000);
        host_run <= 1'b1;
        tick(8);
        calls();
        req(0, 1'b0, 1'b1);
        chk(status, {smmc_pkg::SMMC_EVC_ABORT, smmc_pkg::SMMC_EVN_ABORT});
        line_break <= 1'b1;
        wait_mode(2'h0);
        tick(10);
        chk(16'({mode, drv_en}), 16'h0000);
        req(1, 1'b0, 1'b1);
        line_break <= 1'b0;
        tick(4);
        tally_and_finish();
    end
endmodule
